/* File: verilog/mbc_consts.svh */
/*
 * Constants for the memory bus control block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion from the design modules and the testbench only.
 */
`ifndef MBC_CONSTS_SVH
`define MBC_CONSTS_SVH

// ************************************************************
// Register offsets (byte addresses on APB)
// ************************************************************
`define MBC_CTRL_OFS 12'h000
`define MBC_STAT_OFS 12'h004
`define MBC_ACC_OFS 12'h008
`define MBC_ADDR_OFS 12'h00C
`define MBC_PSR_OFS 12'h010

// ************************************************************
// Control register fields
// ************************************************************
`define MBC_CTRL_BIGEND 0
`define MBC_CTRL_LATEABT 1
`define MBC_CTRL_PROG 2
`define MBC_CTRL_DATA 3
`define MBC_CTRL_RESET 32'h0000000C

// ************************************************************
// Access register fields
// ************************************************************
`define MBC_ACC_GO 0
`define MBC_ACC_WRITE 1
`define MBC_ACC_SEQ 2

// ************************************************************
// Status register fields
// ************************************************************
`define MBC_STAT_BUSY 0
`define MBC_STAT_IRQ 1
`define MBC_STAT_FIQ 2
`define MBC_STAT_IRQ_TAKE 3
`define MBC_STAT_FIQ_TAKE 4
`define MBC_STAT_RESET 5
`define MBC_STAT_CACHE_EN 6
`define MBC_STAT_WAIT 7

// ************************************************************
// Status register (PSR) fields
// ************************************************************
`define MBC_PSR_I 7
`define MBC_PSR_F 6
`define MBC_PSR_RESET 32'h000000D3

// ************************************************************
// Reset address and timing
// ************************************************************
`define MBC_RESET_ADDR 32'h00000000
`define MBC_SYNC_STAGES 3
`define MBC_WAIT_SETTLE 3'h4
`endif

/* File: verilog/mbc_pkg.sv */
/*
 * Types shared by the memory bus control block.
 * Assumes the constants header sits beside it.
 */
package mbc_pkg;
    typedef enum logic [1:0] {
        MBC_IDLE,
        MBC_ANNOUNCE,
        MBC_ACCESS
    } mbc_state_t;
endpackage

/* File: verilog/mbc_sync.sv */
/*
 * Three-flop synchroniser with agreement filter for pin inputs.
 * Assumes the input is asynchronous to pclk.
 */
`timescale 1ns/10ps
`include "mbc_consts.svh"
module mbc_sync
    import mbc_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic reset_level, // level shown after reset until the chain fills
    input wire logic pin_in, // asynchronous pin
    output logic level_out // filtered level
);
    logic [`MBC_SYNC_STAGES-1:0] stage_reg;
    logic [`MBC_SYNC_STAGES-1:0] stage_next;
    logic level_reg;
    logic level_next;
    logic [1:0] fill_reg;
    logic [1:0] fill_next;

    always_comb
    begin
        stage_next = {stage_reg[`MBC_SYNC_STAGES-2:0], pin_in};
        level_next = level_reg;
        fill_next = {fill_reg[0], 1'b1};
        // The first stage is read only by the second one.
        if (stage_reg[1] == stage_reg[2])
        begin
            level_next = stage_reg[2];
        end
        // Until real samples fill the chain, show the idle level, so that the
        // cleared stages cannot fake an edge just after reset.
        if (!fill_reg[1])
        begin
            level_next = reset_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage_reg <= '0;
            level_reg <= 1'b0;
            fill_reg <= 2'b00;
        end
        else
        begin
            stage_reg <= stage_next;
            level_reg <= level_next;
            fill_reg <= fill_next;
        end
    end

    assign level_out = level_reg;
endmodule // mbc_sync

/* File: verilog/mbc_addr_gen.sv */
/*
 * Address generator: restarts at zero, steps during reset idle cycles.
 * Assumes the caller gives a one-cycle load strobe; step may be held high to step once per cycle.
 */
`timescale 1ns/10ps
`include "mbc_consts.svh"
module mbc_addr_gen
    import mbc_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic restart, // force address zero
    input wire logic step, // increment by one word
    input wire logic load, // load new address
    input wire logic [31:0] load_addr, // address to load
    output logic [31:0] addr // current address
);
    logic [31:0] addr_reg;
    logic [31:0] addr_next;

    always_comb
    begin
        addr_next = addr_reg;
        if (restart)
        begin
            addr_next = `MBC_RESET_ADDR;
        end
        else if (load)
        begin
            addr_next = load_addr;
        end
        else if (step)
        begin
            addr_next = addr_reg + 32'h00000004;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_reg <= `MBC_RESET_ADDR;
        end
        else
        begin
            addr_reg <= addr_next;
        end
    end

    assign addr = addr_reg;
endmodule // mbc_addr_gen

/* File: verilog/mbc_top.sv */
/*
 * Memory bus control pins of a processor, with configuration reached
 * over APB. Holds request, sequential, direction, wait, reset entry and
 * restart, interrupt sampling and the factory test pins.
 * Assumes pclk stands for the memory clock; the wait, reset, interrupt and
 * scan reset and scan clock pins are sampled through three-flop synchronisers, addr_latch_enable and scan_tristate_req are not.
 */
`timescale 1ns/10ps
`include "mbc_consts.svh"
module mbc_top
    import mbc_pkg::*;
(
    input wire logic pclk, // memory clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic chip_reset_low, // chip reset pin
    input wire logic wait_stretch_low, // wait pin
    input wire logic interrupt_request_low, // normal interrupt pin
    input wire logic fast_interrupt_request_low, // fast interrupt pin
    input wire logic strap_tie_high, // strap pin
    input wire logic [16:0] test_in, // factory test inputs
    input wire logic test_logic_reset_low, // scan port reset
    input wire logic scan_test_clock, // scan clock, sampled as a pin
    input wire logic scan_tristate_req, // scan port output disable
    input wire logic addr_latch_enable, // address latch enable
    output logic memory_request_low, // pipelined request
    output logic sequential_indicator, // inverse of request
    output logic write_not_read, // direction
    output logic [31:0] mem_addr, // address bus
    output logic [31:0] mem_wdata, // write data lanes
    output logic [3:0] mem_lane_en, // byte lane enables
    output logic [2:0] test_out, // factory test outputs
    output logic [2:0] test_out_oe, // test output enables
    output logic irq_taken, // normal interrupt accepted
    output logic fiq_taken, // fast interrupt accepted
    output logic cache_mmu_wb_en // cache, MMU, write buffer enable
);
    mbc_state_t state_reg, state_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] psr_reg, psr_next;
    logic [31:0] acc_addr_reg, acc_addr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic acc_write_reg, acc_write_next;
    logic go_reg, go_next;
    logic mreq_low_reg, mreq_low_next;
    logic rw_reg, rw_next;
    logic [31:0] lat_addr_reg, lat_addr_next;
    logic [31:0] lane_data_reg, lane_data_next;
    logic [3:0] lane_reg, lane_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [1:0] int_pipe_reg, int_pipe_next;
    logic irq_taken_reg, irq_taken_next;
    logic fiq_taken_reg, fiq_taken_next;
    logic in_reset_reg, in_reset_next;
    logic [2:0] settle_reg, settle_next;
    logic restart_pulse;
    logic addr_step;
    logic addr_load;
    logic [31:0] cur_addr;
    logic rst_sync, wait_sync, irq_sync, fiq_sync, trst_sync;
    logic tck_sync;
    logic access_done;
    logic apb_wr, apb_rd;
    logic irq_en, fiq_en;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    mbc_sync u_sync_rst (.pclk(pclk), .presetn(presetn),
        .reset_level(1'b0), .pin_in(chip_reset_low), .level_out(rst_sync));
    mbc_sync u_sync_wait (.pclk(pclk), .presetn(presetn),
        .reset_level(1'b1), .pin_in(wait_stretch_low),
        .level_out(wait_sync));
    mbc_sync u_sync_irq (.pclk(pclk), .presetn(presetn),
        .reset_level(1'b1), .pin_in(interrupt_request_low),
        .level_out(irq_sync));
    mbc_sync u_sync_fiq (.pclk(pclk), .presetn(presetn),
        .reset_level(1'b1), .pin_in(fast_interrupt_request_low),
        .level_out(fiq_sync));
    mbc_sync u_sync_trst (.pclk(pclk), .presetn(presetn),
        .reset_level(1'b0), .pin_in(test_logic_reset_low),
        .level_out(trst_sync));
    mbc_sync u_sync_tck (.pclk(pclk), .presetn(presetn),
        .reset_level(1'b0), .pin_in(scan_test_clock),
        .level_out(tck_sync));

    // ************************************************************
    // Address generator
    // ************************************************************
    mbc_addr_gen u_addr (.pclk(pclk), .presetn(presetn),
        .restart(restart_pulse), .step(addr_step), .load(addr_load),
        .load_addr(acc_addr_reg), .addr(cur_addr));

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    // The wait pin reaches us through the synchroniser, so an access lasts
    // long enough for a stretch request to be seen before it may end.
    assign access_done = (state_reg == MBC_ACCESS) &&
        (settle_reg == `MBC_WAIT_SETTLE) && wait_sync;
    assign restart_pulse = in_reset_reg && rst_sync;
    assign addr_step = in_reset_reg && !rst_sync;
    assign addr_load = (state_reg == MBC_IDLE) && go_reg && !in_reset_reg;
    assign irq_en = !psr_reg[`MBC_PSR_I];
    assign fiq_en = !psr_reg[`MBC_PSR_F];

    // ************************************************************
    // Access sequencer
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        mreq_low_next = mreq_low_reg;
        rw_next = rw_reg;
        go_next = go_reg;
        in_reset_next = !rst_sync;
        settle_next = 3'h0;
        if (state_reg == MBC_ACCESS)
        begin
            settle_next = settle_reg;
            if (settle_reg != `MBC_WAIT_SETTLE)
            begin
                settle_next = settle_reg + 3'h1;
            end
        end
        if (apb_wr && paddr == `MBC_ACC_OFS)
        begin
            go_next = pwdata[`MBC_ACC_GO];
        end
        if (in_reset_reg || !rst_sync)
        begin
            state_next = MBC_IDLE;
            mreq_low_next = 1'b1;
            rw_next = 1'b0;
            go_next = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                MBC_IDLE:
                begin
                    if (go_reg)
                    begin
                        mreq_low_next = 1'b0;
                        go_next = 1'b0;
                        state_next = MBC_ANNOUNCE;
                    end
                end
                MBC_ANNOUNCE:
                begin
                    if (addr_latch_enable)
                    begin
                        rw_next = acc_write_reg;
                    end
                    state_next = MBC_ACCESS;
                end
                MBC_ACCESS:
                begin
                    if (access_done)
                    begin
                        mreq_low_next = 1'b1;
                        state_next = MBC_IDLE;
                    end
                end
                default:
                begin
                    state_next = MBC_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Address latch and byte lanes
    // ************************************************************
    always_comb
    begin
        lat_addr_next = lat_addr_reg;
        lane_data_next = lane_data_reg;
        lane_next = lane_reg;
        if (addr_latch_enable)
        begin
            lat_addr_next = cur_addr;
        end
        if (state_reg == MBC_ANNOUNCE)
        begin
            if (ctrl_reg[`MBC_CTRL_BIGEND])
            begin
                lane_data_next = {wdata_reg[7:0], wdata_reg[15:8],
                    wdata_reg[23:16], wdata_reg[31:24]};
            end
            else
            begin
                lane_data_next = wdata_reg;
            end
            lane_next = acc_write_reg ? 4'hF : 4'h0;
        end
    end

    // ************************************************************
    // Registers over APB
    // ************************************************************
    always_comb
    begin
        ctrl_next = ctrl_reg;
        psr_next = psr_reg;
        acc_addr_next = acc_addr_reg;
        wdata_next = wdata_reg;
        acc_write_next = acc_write_reg;
        prdata_next = prdata_reg;
        irq_taken_next = 1'b0;
        fiq_taken_next = 1'b0;
        int_pipe_next = {!irq_sync, !fiq_sync};
        if (apb_wr)
        begin
            unique case (paddr)
                `MBC_CTRL_OFS: ctrl_next = {28'h0000000, pwdata[3:0]};
                `MBC_ADDR_OFS: acc_addr_next = {pwdata[31:2], 2'b00};
                `MBC_PSR_OFS: psr_next = pwdata;
                `MBC_ACC_OFS: acc_write_next = pwdata[`MBC_ACC_WRITE];
                `MBC_STAT_OFS: wdata_next = pwdata;
                default: ;
            endcase
        end
        if (apb_rd)
        begin
            unique case (paddr)
                `MBC_CTRL_OFS: prdata_next = ctrl_reg;
                `MBC_ADDR_OFS: prdata_next = acc_addr_reg;
                `MBC_PSR_OFS: prdata_next = psr_reg;
                `MBC_ACC_OFS: prdata_next = {29'h0, !mreq_low_reg,
                    acc_write_reg, go_reg};
                `MBC_STAT_OFS: prdata_next = {24'h0, !wait_sync,
                    cache_mmu_wb_en, in_reset_reg, fiq_taken_reg,
                    irq_taken_reg, !fiq_sync, !irq_sync,
                    state_reg != MBC_IDLE};
                default: prdata_next = 32'h00000000;
            endcase
        end
        if (!in_reset_reg && int_pipe_reg[0] && fiq_en)
        begin
            fiq_taken_next = 1'b1;
            psr_next[`MBC_PSR_F] = 1'b1;
            psr_next[`MBC_PSR_I] = 1'b1;
        end
        else if (!in_reset_reg && int_pipe_reg[1] && irq_en)
        begin
            irq_taken_next = 1'b1;
            psr_next[`MBC_PSR_I] = 1'b1;
        end
        if (in_reset_reg)
        begin
            psr_next = `MBC_PSR_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= MBC_IDLE;
            ctrl_reg <= `MBC_CTRL_RESET;
            psr_reg <= `MBC_PSR_RESET;
            acc_addr_reg <= 32'h00000000;
            wdata_reg <= 32'h00000000;
            acc_write_reg <= 1'b0;
            go_reg <= 1'b0;
            mreq_low_reg <= 1'b1;
            rw_reg <= 1'b0;
            lat_addr_reg <= 32'h00000000;
            lane_data_reg <= 32'h00000000;
            lane_reg <= 4'h0;
            prdata_reg <= 32'h00000000;
            int_pipe_reg <= 2'h0;
            irq_taken_reg <= 1'b0;
            fiq_taken_reg <= 1'b0;
            in_reset_reg <= 1'b1;
            settle_reg <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            psr_reg <= psr_next;
            acc_addr_reg <= acc_addr_next;
            wdata_reg <= wdata_next;
            acc_write_reg <= acc_write_next;
            go_reg <= go_next;
            mreq_low_reg <= mreq_low_next;
            rw_reg <= rw_next;
            lat_addr_reg <= lat_addr_next;
            lane_data_reg <= lane_data_next;
            lane_reg <= lane_next;
            prdata_reg <= prdata_next;
            int_pipe_reg <= int_pipe_next;
            irq_taken_reg <= irq_taken_next;
            fiq_taken_reg <= fiq_taken_next;
            in_reset_reg <= in_reset_next;
            settle_reg <= settle_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_reg;
    assign memory_request_low = mreq_low_reg;
    assign sequential_indicator = !mreq_low_reg;
    assign write_not_read = rw_reg;
    assign mem_addr = lat_addr_reg;
    assign mem_wdata = lane_data_reg;
    assign mem_lane_en = lane_reg;
    assign test_out = 3'h0;
    assign test_out_oe = (scan_tristate_req && trst_sync && tck_sync) ?
        3'h0 : 3'h7;
    assign irq_taken = irq_taken_reg;
    assign fiq_taken = fiq_taken_reg;
    assign cache_mmu_wb_en = !in_reset_reg;
endmodule // mbc_top

/* File: sim/mbc_top_monitor.sv */
/* Checker for the memory bus control pins of mbc_top.
   Assumes it is bound to mbc_top and sees only its ports. */
`timescale 1ns/10ps
module mbc_monitor
(
    input wire logic pclk, // memory clock
    input wire logic presetn, // async reset, active low
    input wire logic chip_reset_low, // chip reset pin
    input wire logic wait_stretch_low, // wait pin
    input wire logic interrupt_request_low, // normal interrupt pin
    input wire logic scan_tristate_req, // scan output disable
    input wire logic addr_latch_enable, // address latch enable
    input wire logic [16:0] test_in, // factory test inputs
    input wire logic memory_request_low, // pipelined request
    input wire logic sequential_indicator, // inverse of request
    input wire logic write_not_read, // direction
    input wire logic [31:0] mem_addr, // address bus
    input wire logic [2:0] test_out, // factory test outputs
    input wire logic [2:0] test_out_oe, // test output enables
    input wire logic irq_taken, // normal interrupt accepted
    input wire logic fiq_taken, // fast interrupt accepted
    input wire logic cache_mmu_wb_en // cache enable
);
// ************************************************************
// Pin relations
// ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    seq_inverse_a: assert property (
        sequential_indicator == !memory_request_low)
        else $error("indicator not inverse of request");
    test_low_a: assert property (
        test_in == 17'h0 |-> test_out == 3'h0)
        else $error("test outputs not low");
    test_drive_a: assert property (
        !scan_tristate_req [*5] |-> test_out_oe == 3'h7)
        else $error("test outputs released without scan");
    reset_disable_a: assert property (
        !chip_reset_low [*6] |-> !cache_mmu_wb_en)
        else $error("cache enabled in reset");
    reset_idle_a: assert property (
        !chip_reset_low [*6] |-> memory_request_low)
        else $error("request during reset");
    reset_step_a: assert property (
        !chip_reset_low [*6] ##0 addr_latch_enable
        |-> ##[1:3] mem_addr != $past(mem_addr))
        else $error("address not stepping in reset");
    restart_zero_a: assert property (
        $rose(cache_mmu_wb_en) && addr_latch_enable
        |-> ##[0:2] mem_addr == 32'h0)
        else $error("restart not at address zero");
    latch_hold_a: assert property (
        !addr_latch_enable
        |=> $stable(mem_addr) && $stable(write_not_read))
        else $error("latched outputs moved");
    wait_stretch_a: assert property (
        !wait_stretch_low [*5] ##0 !memory_request_low
        |=> !memory_request_low)
        else $error("access ended during wait");
    irq_sync_a: assert property (
        irq_taken |-> !$past(interrupt_request_low, 3))
        else $error("interrupt taken without request");
    irq_prio_a: assert property (
        !(irq_taken && fiq_taken))
        else $error("both interrupts taken");
    cov_access: cover property ($fell(memory_request_low));
    cov_irq: cover property (irq_taken);
    cov_reset: cover property ($rose(cache_mmu_wb_en));
endmodule // mbc_monitor
bind mbc_top mbc_monitor u_mon (.pclk, .presetn, .chip_reset_low,
    .wait_stretch_low, .interrupt_request_low, .scan_tristate_req,
    .addr_latch_enable, .test_in, .memory_request_low,
    .sequential_indicator, .write_not_read, .mem_addr, .test_out,
    .test_out_oe, .irq_taken, .fiq_taken, .cache_mmu_wb_en);

/* File: sim/mbc_mem_model.sv */
/* Memory system model: stretches each access with the wait pin.
   Assumes the request pin and chip reset of the block under test. */
`timescale 1ns/10ps
module mbc_mem_model
(
    input wire logic pclk, // memory clock
    input wire logic chip_reset_low, // chip reset pin
    input wire logic memory_request_low, // request from block
    input wire logic [7:0] wait_cycles, // stretch per access
    output logic wait_stretch_low // wait pin
);
    logic [7:0] cnt;
    initial
    begin
        wait_stretch_low = 1'b1;
        cnt = 8'h00;
    end
    // low phase, reset high
    // The pin moves only at the falling edge, inside the low phase.
    always @(negedge pclk)
    begin
        if (!chip_reset_low || memory_request_low)
        begin
            wait_stretch_low <= 1'b1;
            cnt <= 8'h00;
        end
        else if (cnt < wait_cycles)
        begin
            wait_stretch_low <= 1'b0;
            cnt <= cnt + 8'h01;
        end
        else
            wait_stretch_low <= 1'b1;
    end
endmodule // mbc_mem_model

/* File: sim/tb_mbc_top.sv */
/* Self-checking bench for mbc_top over APB and its pins.
   Assumes the constants header is on the include path. */
`timescale 1ns/10ps
`include "mbc_consts.svh"
module tb_mbc_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, a1, mem_addr;
    logic pready, chip_reset_low = 0, wait_stretch_low;
    logic interrupt_request_low = 1, fast_interrupt_request_low = 1;
    logic test_logic_reset_low = 0, addr_latch_enable = 1;
    logic memory_request_low, sequential_indicator, write_not_read;
    logic irq_taken, fiq_taken, cache_mmu_wb_en, hit;
    logic [7:0] wcyc = 8'h00;
    int fail_count = 0, tests_run = 0, cycles = 0, n;
    always #50 pclk = ~pclk;
    mbc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr(), .chip_reset_low,
        .wait_stretch_low, .interrupt_request_low,
        .fast_interrupt_request_low, .strap_tie_high(1'b1),
        .test_in(17'h0), .test_logic_reset_low, .scan_test_clock(1'b0),
        .scan_tristate_req(1'b0), .addr_latch_enable,
        .memory_request_low, .sequential_indicator, .write_not_read,
        .mem_addr, .mem_wdata(), .mem_lane_en(), .test_out(),
        .test_out_oe(), .irq_taken, .fiq_taken, .cache_mmu_wb_en);
    mbc_mem_model u_mem (.pclk, .chip_reset_low, .memory_request_low,
        .wait_cycles(wcyc), .wait_stretch_low);
// ************************************************************
// Tasks
// ************************************************************
    task automatic test_done();
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles > 20000)
        begin
            fail_count = fail_count + 1;
            test_done();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One access; ea and ed are the expected latched address and direction.
    task automatic access(input logic w, input logic [31:0] a,
        input logic [7:0] wc, input logic le, input logic [31:0] ea,
        input logic ed);
        wcyc <= wc;
        addr_latch_enable <= le;
        apb(1'b1, `MBC_ADDR_OFS, a);
        apb(1'b1, `MBC_ACC_OFS, {30'h0, w, 1'b1});
        for (n = 0; n < 20 && memory_request_low !== 1'b0; n++)
            @(negedge pclk);
        check(memory_request_low, 1'b0);
        @(negedge pclk);
        check(write_not_read, ed);
        check(mem_addr, ea);
        for (n = 1; n < 60 && memory_request_low !== 1'b1; n++)
            @(negedge pclk);
        check(n > wc, 1'b1);
    endtask
// ************************************************************
// Main sequence
// ************************************************************
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        chip_reset_low <= 1'b1;
        test_logic_reset_low <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, `MBC_CTRL_OFS, 32'h0);
        check(q, `MBC_CTRL_RESET);
        apb(1'b0, `MBC_PSR_OFS, 32'h0);
        check(q, `MBC_PSR_RESET);
        apb(1'b0, 12'h040, 32'h0);
        check(q, 32'h0);
        apb(1'b1, `MBC_CTRL_OFS, 32'hF);
        apb(1'b0, `MBC_CTRL_OFS, 32'h0);
        check(q, 32'hF);
        access(1'b1, 32'h100, 8'h00, 1'b1, 32'h100, 1'b1);
        access(1'b0, 32'h200, 8'h08, 1'b1, 32'h200, 1'b0);
        access(1'b1, 32'h300, 8'h02, 1'b0, 32'h200, 1'b0);
        addr_latch_enable <= 1'b1;
        chip_reset_low <= 1'b0;
        repeat (8) @(posedge pclk);
        check(cache_mmu_wb_en, 1'b0);
        check(memory_request_low, 1'b1);
        a1 = mem_addr;
        repeat (2) @(posedge pclk);
        check(mem_addr != a1, 1'b1);
        chip_reset_low <= 1'b1;
        for (n = 0; n < 20 && cache_mmu_wb_en !== 1'b1; n++)
            @(posedge pclk);
        @(posedge pclk);
        check(mem_addr, 32'h0);
        apb(1'b1, `MBC_PSR_OFS, 32'h13);
        interrupt_request_low <= 1'b0;
        for (n = 0; n < 20 && irq_taken !== 1'b1; n++)
            @(posedge pclk);
        check(irq_taken, 1'b1);
        apb(1'b0, `MBC_PSR_OFS, 32'h0);
        check(q[7], 1'b1);
        hit = 1'b0;
        repeat (20)
        begin
            @(posedge pclk);
            if (irq_taken === 1'b1)
                hit = 1'b1;
        end
        check(hit, 1'b0);
        // The fast request is raised while only I is masked, so it is taken at once; then both are unmasked together.
        fast_interrupt_request_low <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b1, `MBC_PSR_OFS, 32'h13);
        for (n = 0; n < 20 && irq_taken !== 1'b1 && fiq_taken !== 1'b1; n++)
            @(posedge pclk);
        check(fiq_taken, 1'b1);
        check(irq_taken, 1'b0);
        interrupt_request_low <= 1'b1;
        fast_interrupt_request_low <= 1'b1;
        test_done();
    end
endmodule // tb_mbc_top
